// ---- shared/hdca_pkg.sv ----
package hdca_pkg;

    // ----------------------------------------------------------------
    // Field layout of the processor data word
    // ----------------------------------------------------------------
    localparam int          HDCA_DW          = 16;
    localparam int          HDCA_SUBADR_LSB  = 12;   // accumulator bits 0..3 (bit 0 is MSB)
    localparam int          HDCA_SUBADR_W    = 4;
    localparam int          HDCA_LEN_W       = 12;   // accumulator bits 4..15
    localparam int          HDCA_ERR_W       = 6;    // data bits 10..15
    localparam int          HDCA_CNT_W       = 17;   // up to 65536 words

    // ----------------------------------------------------------------
    // Counting constants and reset values
    // ----------------------------------------------------------------
    localparam int          HDCA_WORDS_PER_SUB = 16;
    localparam int          HDCA_SECTOR_WORDS  = 256;
    localparam logic [15:0] HDCA_ADDR_RST      = 16'h0000;
    localparam logic [15:0] HDCA_ZERO_WORD     = 16'h0000;

    // Device code returned on interrupt acknowledge; value is arbitrary.
    localparam logic [15:0] HDCA_DEV_CODE_DEF  = 16'h0015;

    // ----------------------------------------------------------------
    // Data channel states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        HDCA_CH_IDLE = 3'b001,
        HDCA_CH_REQ  = 3'b010,
        HDCA_CH_SEL  = 3'b100
    } hdca_ch_state_t;

    // Processor order of bits: accumulator bit n sits at vector bit 15-n.
    function automatic logic [HDCA_LEN_W-1:0] hdca_len_field(input logic [15:0] w);
        return w[HDCA_LEN_W-1:0];
    endfunction : hdca_len_field

endpackage : hdca_pkg

// ---- hdl/hdca_word_counter.sv ----
`timescale 1ns/1ps
module hdca_word_counter
    import hdca_pkg::*;
#(
    parameter int CNT_W = HDCA_CNT_W
) (
    input  wire logic                  i_clk,          // System clock.
    input  wire logic                  i_arst_n,       // Asynchronous reset.
    input  wire logic                  i_clear,        // Start: clear all stages.
    input  wire logic                  i_load,         // Length load strobe.
    input  wire logic [HDCA_LEN_W-1:0] i_len,          // Length in subsectors.
    input  wire logic                  i_advance,      // Address gate pulse.
    output logic                       o_end           // End-of-operation flag.
);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] limit_r;
    logic [CNT_W-1:0] limit_nxt;
    logic             end_r;
    logic             end_nxt;

    always_comb begin
        count_nxt = count_r;
        limit_nxt = limit_r;
        end_nxt   = end_r;
        if (i_clear) begin
            count_nxt = '0;
            limit_nxt = CNT_W'(HDCA_SECTOR_WORDS);
            end_nxt   = 1'b0;
        end else begin
            if (i_load) begin
                if (i_len == '0) begin
                    limit_nxt = CNT_W'(4096 * HDCA_WORDS_PER_SUB);
                end else begin
                    limit_nxt = CNT_W'(i_len) * CNT_W'(HDCA_WORDS_PER_SUB);
                end
            end
            if (i_advance && !end_r) begin
                count_nxt = count_r + CNT_W'(1);
                if (count_r + CNT_W'(1) == limit_r) begin
                    end_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count_r <= '0;
            limit_r <= CNT_W'(HDCA_SECTOR_WORDS);
            end_r   <= 1'b0;
        end else begin
            count_r <= count_nxt;
            limit_r <= limit_nxt;
            end_r   <= end_nxt;
        end
    end

    assign o_end = end_r;

endmodule : hdca_word_counter

// ---- hdl/hdca_adapter.sv ----
`timescale 1ns/1ps
// How it works
// - Length instruction bits 0-3 give subsector address
// - Bits 4-15 load subsector length counter
// - Start or pulse strobe clears counter
// - Length data strobe makes load strobe
// - Length 1..4096 subsectors, zero means 4096
// - Address gate advances counter, sets end
// - Without length instruction, count 256 words
// - Unit/track instruction passes data to formatter
// - Address instruction loads inverted data lines
// - Write data inverted toward formatter
// - First address gate drives initial address
// - Address input returns address register
// - Read data inverted onto data lines
// - Status input returns error bits 10-15
// - Interrupt acknowledge drives device code
// - Request flag set on request enable
// - Priority passes through unless requesting
// - Acknowledge with priority sets select, gate
// - Read asserts channel mode line
// - Address gate presets busy flag
// - Channel strobes become formatter pulses
// - Busy write enables data register transfer
// - Busy address input returns zeros
// - Falling out strobe clears busy
// - I/O reset clears address register
module hdca_adapter
    import hdca_pkg::*;
#(
    parameter logic [15:0] DEV_CODE = HDCA_DEV_CODE_DEF
) (
    input  wire logic                     I_CLK,          // 25 MHz clock.
    input  wire logic                     I_ARST_N,       // Async reset, active low.
    input  wire logic [HDCA_DW-1:0]       I_DATA,         // Processor data lines in.
    output logic      [HDCA_DW-1:0]       O_DATA,         // Processor data lines out.
    output logic                          O_DATA_OE,      // Drives data lines.
    input  wire logic                     I_UNIT_TRACK_OUTPUT_INSTR, // Unit/track out.
    input  wire logic                     I_ADDRESS_OUTPUT_INSTR,    // Address out.
    input  wire logic                     I_LENGTH_DATA_STROBE,      // Length out.
    input  wire logic                     I_STATUS_INPUT_INSTR,      // Status in.
    input  wire logic                     I_ADDRESS_INPUT_INSTR,     // Address in.
    input  wire logic                     I_HOST_START_STROBE,       // Start.
    input  wire logic                     I_HOST_PULSE_STROBE,       // Pulse.
    input  wire logic                     I_IO_RESET_PULSE,          // I/O reset.
    input  wire logic                     I_INT_ACK,                 // Interrupt ack.
    input  wire logic                     I_INT_PENDING,             // Int request held.
    input  wire logic                     I_INT_PRIORITY_IN,         // Int priority in.
    input  wire logic                     I_REQUEST_ENABLE_STROBE,   // Request enable.
    input  wire logic                     I_CHANNEL_PRIORITY_IN,     // Chan priority in.
    input  wire logic                     I_CHANNEL_ACKNOWLEDGE,     // Chan acknowledge.
    input  wire logic                     I_CHANNEL_IN_STROBE,       // Chan in strobe.
    input  wire logic                     I_CHANNEL_OUT_STROBE,      // Chan out strobe.
    input  wire logic                     I_WRITE_OPERATION_FLAG,    // Write op.
    input  wire logic                     I_READ_OPERATION_FLAG,     // Read op.
    input  wire logic                     I_DATA_REGISTER_READY,     // Data reg ready.
    input  wire logic [HDCA_DW-1:0]       I_FMT_DATA,     // Formatter read data.
    input  wire logic [HDCA_ERR_W-1:0]    I_FMT_ERROR,    // Formatter error register.
    output logic      [HDCA_DW-1:0]       O_FMT_BUS,      // Common bus to formatter.
    output logic                          O_UNIT_TRACK_LOAD,    // Unit/track load.
    output logic                          O_SUBSECTOR_ADDR_LOAD,// Subsector addr load.
    output logic      [HDCA_SUBADR_W-1:0] O_SUBSECTOR_ADDR,     // Subsector address.
    output logic                          O_DATA_XFER_EN,       // Write data enable.
    output logic                          O_REGISTER_SET_PULSE, // Write strobe.
    output logic                          O_READ_DATA_AVAILABLE,// Read strobe.
    output logic                          O_STATUS_READ_STROBE, // Status strobe.
    output logic                          O_CHANNEL_REQUEST_LINE,  // Channel request.
    output logic                          O_CHANNEL_PRIORITY_OUT,  // Priority out.
    output logic                          O_CHANNEL_MODE_LINE,     // Data-in mode.
    output logic                          O_CHANNEL_BUSY,          // Busy.
    output logic                          O_ADDRESS_GATE_PULSE,    // Address gate.
    output logic                          O_LENGTH_LOADED_FLAG,    // Length loaded.
    output logic                          O_END_OF_OPERATION,      // End flag.
    output logic      [HDCA_DW-1:0]       O_MEMORY_ADDRESS         // Address register.
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    localparam int NSYNC = 20;

    logic [NSYNC-1:0]   sy1_r;
    logic [NSYNC-1:0]   sy2_r;
    logic [NSYNC-1:0]   sy3_r;
    logic [HDCA_DW-1:0] dat1_r;
    logic [HDCA_DW-1:0] dat2_r;
    logic [HDCA_DW-1:0] fd1_r;
    logic [HDCA_DW-1:0] fd2_r;
    logic [HDCA_ERR_W-1:0] fe1_r;
    logic [HDCA_ERR_W-1:0] fe2_r;
    logic [NSYNC-1:0]   sy_raw;

    assign sy_raw = {I_UNIT_TRACK_OUTPUT_INSTR, I_ADDRESS_OUTPUT_INSTR, I_LENGTH_DATA_STROBE,
                     I_STATUS_INPUT_INSTR, I_ADDRESS_INPUT_INSTR, I_HOST_START_STROBE,
                     I_HOST_PULSE_STROBE, I_IO_RESET_PULSE, I_INT_ACK, I_INT_PENDING,
                     I_INT_PRIORITY_IN, I_REQUEST_ENABLE_STROBE, I_CHANNEL_PRIORITY_IN,
                     I_CHANNEL_ACKNOWLEDGE, I_CHANNEL_IN_STROBE, I_CHANNEL_OUT_STROBE,
                     I_WRITE_OPERATION_FLAG, I_READ_OPERATION_FLAG, I_DATA_REGISTER_READY,
                     1'b0};

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sy1_r  <= '0;
            sy2_r  <= '0;
            sy3_r  <= '0;
            dat1_r <= '0;
            dat2_r <= '0;
            fd1_r  <= '0;
            fd2_r  <= '0;
            fe1_r  <= '0;
            fe2_r  <= '0;
        end else begin
            sy1_r  <= sy_raw;
            sy2_r  <= sy1_r;
            sy3_r  <= sy2_r;
            dat1_r <= I_DATA;
            dat2_r <= dat1_r;
            fd1_r  <= I_FMT_DATA;
            fd2_r  <= fd1_r;
            fe1_r  <= I_FMT_ERROR;
            fe2_r  <= fe1_r;
        end
    end

    // Levels after synchronising, and rising edges of the strobes.
    logic [NSYNC-1:0] rise;
    logic [NSYNC-1:0] fall;
    assign rise = sy2_r & ~sy3_r;
    assign fall = ~sy2_r & sy3_r;

    logic utk_p, adr_p, len_p, sti_lv, adi_p, start_p, ioreset_p, iack_lv, ipend_lv;
    logic ipri_lv, rqen_p, cpri_lv, cack_p, cin_p, cout_p, cout_f, write_operation_flag_lv, read_operation_flag_lv, drr_lv;
    assign utk_p     = rise[19];
    assign adr_p     = rise[18];
    assign len_p     = rise[17];
    assign sti_lv    = sy2_r[16];
    assign adi_p     = rise[15];
    assign start_p   = rise[14] | rise[13];
    assign ioreset_p = rise[12];
    assign iack_lv   = sy2_r[11];
    assign ipend_lv  = sy2_r[10];
    assign ipri_lv   = sy2_r[9];
    assign rqen_p    = rise[8];
    assign cpri_lv   = sy2_r[7];
    assign cack_p    = rise[6];
    assign cin_p     = rise[5];
    assign cout_p    = rise[4];
    assign cout_f    = fall[4];
    assign write_operation_flag_lv   = sy2_r[3];
    assign read_operation_flag_lv   = sy2_r[2];
    assign drr_lv    = sy2_r[1];

    // ----------------------------------------------------------------
    // Data channel handshake
    // ----------------------------------------------------------------
    hdca_ch_state_t st_r, st_nxt;
    logic busy_r, busy_nxt;
    logic first_r, first_nxt;
    logic [HDCA_DW-1:0] maddr_r, maddr_nxt;
    logic adg;
    logic end_flag;

    always_comb begin
        st_nxt = st_r;
        adg    = 1'b0;
        unique case (st_r)
            HDCA_CH_IDLE: begin
                if (rqen_p && (write_operation_flag_lv || read_operation_flag_lv) && drr_lv && !busy_r && !end_flag) begin
                    st_nxt = HDCA_CH_REQ;
                end
            end
            HDCA_CH_REQ: begin
                if (cack_p && cpri_lv) begin
                    st_nxt = HDCA_CH_SEL;
                    adg    = 1'b1;
                end
            end
            HDCA_CH_SEL: begin
                if (!busy_r) begin
                    st_nxt = HDCA_CH_IDLE;
                end
            end
        endcase
        if (start_p) begin
            st_nxt = HDCA_CH_IDLE;
        end
    end

    always_comb begin
        busy_nxt = busy_r;
        if (adg) begin
            busy_nxt = 1'b1;
        end else if ((cout_f && write_operation_flag_lv) || (cin_p && read_operation_flag_lv)) begin
            busy_nxt = 1'b0;
        end
        first_nxt = first_r;
        maddr_nxt = maddr_r;
        if (ioreset_p) begin
            maddr_nxt = HDCA_ADDR_RST;
            first_nxt = 1'b0;
        end else if (adr_p) begin
            maddr_nxt = ~dat2_r;
            first_nxt = 1'b1;
        end else if (adg) begin
            maddr_nxt = maddr_r + 16'h0001;
            first_nxt = 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_r    <= HDCA_CH_IDLE;
            busy_r  <= 1'b0;
            first_r <= 1'b0;
            maddr_r <= HDCA_ADDR_RST;
        end else begin
            st_r    <= st_nxt;
            busy_r  <= busy_nxt;
            first_r <= first_nxt;
            maddr_r <= maddr_nxt;
        end
    end

    assign O_CHANNEL_REQUEST_LINE = (st_r == HDCA_CH_REQ);
    assign O_CHANNEL_PRIORITY_OUT = cpri_lv && (st_r != HDCA_CH_REQ);
    assign O_CHANNEL_MODE_LINE    = (st_r == HDCA_CH_SEL) && read_operation_flag_lv;
    assign O_CHANNEL_BUSY         = busy_r;
    assign O_ADDRESS_GATE_PULSE   = adg;
    assign O_MEMORY_ADDRESS       = maddr_r;
    assign O_REGISTER_SET_PULSE   = busy_r && cout_p;
    assign O_READ_DATA_AVAILABLE  = busy_r && cin_p;
    assign O_STATUS_READ_STROBE   = sti_lv;
    assign O_DATA_XFER_EN         = busy_r && write_operation_flag_lv;

    // ----------------------------------------------------------------
    // Word transfer counter
    // ----------------------------------------------------------------
    logic lenld_r, lenld_nxt;

    always_comb begin
        lenld_nxt = lenld_r;
        if (len_p) begin
            lenld_nxt = 1'b1;
        end else if (start_p) begin
            lenld_nxt = 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            lenld_r <= 1'b0;
        end else begin
            lenld_r <= lenld_nxt;
        end
    end

    assign O_LENGTH_LOADED_FLAG = lenld_r;

    hdca_word_counter #(
        .CNT_W (HDCA_CNT_W)
    ) u_cnt (
        .i_clk     (I_CLK),
        .i_arst_n  (I_ARST_N),
        .i_clear   (start_p),
        .i_load    (len_p),
        .i_len     (hdca_len_field(~dat2_r)),
        .i_advance (adg),
        .o_end     (end_flag)
    );

    assign O_END_OF_OPERATION = end_flag;

    // ----------------------------------------------------------------
    // Formatter bus and processor data return
    // ----------------------------------------------------------------
    logic [HDCA_DW-1:0] fbus_r, fbus_nxt;
    logic               utl_r, utl_nxt, sal_r, sal_nxt;
    logic [HDCA_DW-1:0] dout_r, dout_nxt;
    logic               doe_r, doe_nxt;

    always_comb begin
        fbus_nxt = fbus_r;
        utl_nxt  = utk_p;
        sal_nxt  = len_p;
        if (utk_p) begin
            fbus_nxt = ~dat2_r;
        end else if (len_p) begin
            fbus_nxt = ~dat2_r;
        end else if (busy_r && write_operation_flag_lv) begin
            fbus_nxt = ~dat2_r;
        end
        dout_nxt = HDCA_ZERO_WORD;
        doe_nxt  = 1'b1;
        if (iack_lv && ipend_lv && ipri_lv) begin
            dout_nxt = DEV_CODE;
        end else if (adi_p) begin
            dout_nxt = busy_r ? HDCA_ZERO_WORD : maddr_r;
        end else if (adg && first_r) begin
            dout_nxt = maddr_r;
        end else if (cin_p && busy_r && read_operation_flag_lv) begin
            dout_nxt = ~fd2_r;
        end else if (sti_lv) begin
            dout_nxt = {10'h000, ~fe2_r};
        end else begin
            doe_nxt  = 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            fbus_r <= '0;
            utl_r  <= 1'b0;
            sal_r  <= 1'b0;
            dout_r <= '0;
            doe_r  <= 1'b0;
        end else begin
            fbus_r <= fbus_nxt;
            utl_r  <= utl_nxt;
            sal_r  <= sal_nxt;
            dout_r <= dout_nxt;
            doe_r  <= doe_nxt;
        end
    end

    assign O_FMT_BUS             = fbus_r;
    assign O_UNIT_TRACK_LOAD     = utl_r;
    assign O_SUBSECTOR_ADDR_LOAD = sal_r;
    assign O_SUBSECTOR_ADDR      = fbus_r[HDCA_DW-1:HDCA_SUBADR_LSB];
    assign O_DATA                = dout_r;
    assign O_DATA_OE             = doe_r;

endmodule : hdca_adapter

// ---- bench/hdca_adapter_asserts.sv ----
`timescale 1ns/1ps
module hdca_adapter_asserts (
    input wire logic I_CLK,                  // Clock.
    input wire logic I_ARST_N,               // Reset, active low.
    input wire logic I_CHANNEL_ACKNOWLEDGE,   // Chan acknowledge.
    input wire logic I_CHANNEL_IN_STROBE,     // Chan in strobe.
    input wire logic I_CHANNEL_OUT_STROBE,    // Chan out strobe.
    input wire logic I_READ_OPERATION_FLAG,   // Read op.
    input wire logic O_CHANNEL_PRIORITY_OUT,  // Priority out.
    input wire logic O_CHANNEL_REQUEST_LINE,  // Channel request.
    input wire logic O_ADDRESS_GATE_PULSE,    // Address gate.
    input wire logic O_CHANNEL_BUSY,          // Busy.
    input wire logic O_DATA_XFER_EN,          // Write data enable.
    input wire logic O_CHANNEL_MODE_LINE,     // Data-in mode.
    input wire logic O_REGISTER_SET_PULSE,    // Write strobe.
    input wire logic O_READ_DATA_AVAILABLE,   // Read strobe.
    input wire logic O_END_OF_OPERATION,      // End flag.
    input wire logic O_SUBSECTOR_ADDR_LOAD,   // Subsector addr load.
    input wire logic O_LENGTH_LOADED_FLAG     // Length loaded.
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_ARST_N);
    sequence s_out_fall;
        $fell(I_CHANNEL_OUT_STROBE) && O_CHANNEL_BUSY;
    endsequence
    sequence s_busy_drop;
        ##[2:6] !O_CHANNEL_BUSY;
    endsequence
    a_prio_block: assert property (
        O_CHANNEL_REQUEST_LINE |-> !O_CHANNEL_PRIORITY_OUT) else $error("Priority passed.");
    a_gate_on_ack: assert property (
        O_ADDRESS_GATE_PULSE |-> $past(I_CHANNEL_ACKNOWLEDGE, 2) && $past(O_CHANNEL_REQUEST_LINE))
        else $error("Gate without acknowledge.");
    a_gate_sets_busy: assert property (
        O_ADDRESS_GATE_PULSE |=> O_CHANNEL_BUSY) else $error("Gate left busy low.");
    a_xfer_needs_busy: assert property (
        O_DATA_XFER_EN |-> O_CHANNEL_BUSY) else $error("Transfer enable while idle.");
    a_mode_on_read: assert property (
        O_ADDRESS_GATE_PULSE && I_READ_OPERATION_FLAG |-> ##[0:1] O_CHANNEL_MODE_LINE)
        else $error("Mode line missing.");
    a_rset_gated: assert property (
        O_REGISTER_SET_PULSE |-> O_CHANNEL_BUSY && $past(I_CHANNEL_OUT_STROBE, 2))
        else $error("Register set without out strobe.");
    a_rdav_gated: assert property (
        O_READ_DATA_AVAILABLE |-> O_CHANNEL_BUSY && $past(I_CHANNEL_IN_STROBE, 2))
        else $error("Read available without in strobe.");
    a_out_clears_busy: assert property (
        s_out_fall |-> s_busy_drop) else $error("Busy held after out strobe.");
    a_req_allowed: assert property (
        $rose(O_CHANNEL_REQUEST_LINE) |-> !O_END_OF_OPERATION && !$past(O_CHANNEL_BUSY))
        else $error("Request while busy or ended.");
    a_len_flag_set: assert property (
        O_SUBSECTOR_ADDR_LOAD |-> ##[0:1] O_LENGTH_LOADED_FLAG) else $error("Length flag low.");
endmodule : hdca_adapter_asserts
bind hdca_adapter hdca_adapter_asserts hdca_adapter_asserts_inst (
    .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_CHANNEL_ACKNOWLEDGE(I_CHANNEL_ACKNOWLEDGE),
    .I_CHANNEL_IN_STROBE(I_CHANNEL_IN_STROBE), .I_CHANNEL_OUT_STROBE(I_CHANNEL_OUT_STROBE),
    .I_READ_OPERATION_FLAG(I_READ_OPERATION_FLAG), .O_CHANNEL_PRIORITY_OUT(O_CHANNEL_PRIORITY_OUT),
    .O_CHANNEL_REQUEST_LINE(O_CHANNEL_REQUEST_LINE), .O_ADDRESS_GATE_PULSE(O_ADDRESS_GATE_PULSE),
    .O_CHANNEL_BUSY(O_CHANNEL_BUSY), .O_DATA_XFER_EN(O_DATA_XFER_EN),
    .O_CHANNEL_MODE_LINE(O_CHANNEL_MODE_LINE), .O_REGISTER_SET_PULSE(O_REGISTER_SET_PULSE),
    .O_READ_DATA_AVAILABLE(O_READ_DATA_AVAILABLE), .O_END_OF_OPERATION(O_END_OF_OPERATION),
    .O_SUBSECTOR_ADDR_LOAD(O_SUBSECTOR_ADDR_LOAD), .O_LENGTH_LOADED_FLAG(O_LENGTH_LOADED_FLAG));

// ---- bench/hdca_chan_model.sv ----
`timescale 1ns/1ps
module hdca_chan_model (
    input  wire logic i_clk,  // Clock.
    input  wire logic i_req,  // Channel request line.
    input  wire logic i_busy, // Channel busy.
    input  wire logic i_mode, // Data-in transfer.
    input  wire logic i_slow, // Slow answers.
    output logic      o_ack,  // Channel acknowledge.
    output logic      o_in,   // Channel in strobe.
    output logic      o_out,  // Channel out strobe.
    output logic      o_rqe   // Request enable strobe.
);
    logic [3:0] cyc;
    // Request enable opens every memory cycle, whether or not anyone asks.
    initial begin
        cyc = 4'h0;
        o_rqe = 1'b0;
        forever begin
            @(negedge i_clk);
            cyc = cyc + 4'h1;
            o_rqe = (cyc[3:2] == 2'b00);
        end
    end
    initial begin
        o_ack = 1'b0;
        o_in = 1'b0;
        o_out = 1'b0;
        forever begin
            @(negedge i_clk);
            if (i_req) begin
                repeat (i_slow ? 12 : 1) @(negedge i_clk);
                o_ack = 1'b1;
                repeat (4) @(negedge i_clk);
                o_ack = 1'b0;
                for (int i = 0; i < 20 && !i_busy; i++) @(negedge i_clk);
                repeat (i_slow ? 20 : 1) @(negedge i_clk);
                if (i_mode) o_in = 1'b1;
                else o_out = 1'b1;
                repeat (4) @(negedge i_clk);
                o_in = 1'b0;
                o_out = 1'b0;
                for (int i = 0; i < 20 && i_busy; i++) @(negedge i_clk);
            end
        end
    end
endmodule : hdca_chan_model

// ---- bench/hdca_adapter_test.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module hdca_adapter_test
    import hdca_pkg::*;
;
    logic        clk, rst_n, ack, cin, cout, rqe, slow, oe, oe_d, int_ack, int_pnd, int_pri;
    logic        prio, wr, rd, rdy, utl, gate, lflag, eop, srs, pout, req, mode, busy;
    logic [7:0]  ins;
    logic [5:0]  err;
    logic [3:0]  sub;
    logic [15:0] d, fmt, odat, mem, fbus, exp_w;
    logic [15:0] expq[$];
    int          bad_count, checks, gates, utl_n;
    hdca_adapter hdca_adapter_inst (
        .I_CLK(clk), .I_ARST_N(rst_n), .I_DATA(d), .O_DATA(odat), .O_DATA_OE(oe),
        .I_UNIT_TRACK_OUTPUT_INSTR(ins[0]), .I_ADDRESS_OUTPUT_INSTR(ins[1]),
        .I_LENGTH_DATA_STROBE(ins[2]), .I_ADDRESS_INPUT_INSTR(ins[3]), .I_HOST_START_STROBE(ins[4]),
        .I_IO_RESET_PULSE(ins[5]), .I_STATUS_INPUT_INSTR(ins[6]), .I_HOST_PULSE_STROBE(ins[7]),
        .I_INT_ACK(int_ack), .I_INT_PENDING(int_pnd), .I_INT_PRIORITY_IN(int_pri),
        .I_REQUEST_ENABLE_STROBE(rqe), .I_CHANNEL_PRIORITY_IN(prio), .I_CHANNEL_ACKNOWLEDGE(ack),
        .I_CHANNEL_IN_STROBE(cin), .I_CHANNEL_OUT_STROBE(cout), .I_WRITE_OPERATION_FLAG(wr),
        .I_READ_OPERATION_FLAG(rd), .I_DATA_REGISTER_READY(rdy), .I_FMT_DATA(fmt),
        .I_FMT_ERROR(err), .O_FMT_BUS(fbus), .O_UNIT_TRACK_LOAD(utl), .O_SUBSECTOR_ADDR_LOAD(),
        .O_SUBSECTOR_ADDR(sub), .O_DATA_XFER_EN(), .O_REGISTER_SET_PULSE(),
        .O_READ_DATA_AVAILABLE(), .O_STATUS_READ_STROBE(srs), .O_CHANNEL_REQUEST_LINE(req),
        .O_CHANNEL_PRIORITY_OUT(pout), .O_CHANNEL_MODE_LINE(mode), .O_CHANNEL_BUSY(busy),
        .O_ADDRESS_GATE_PULSE(gate), .O_LENGTH_LOADED_FLAG(lflag), .O_END_OF_OPERATION(eop),
        .O_MEMORY_ADDRESS(mem));
    hdca_chan_model hdca_chan_model_inst (.i_clk(clk), .i_req(req), .i_busy(busy), .i_mode(mode),
        .i_slow(slow), .o_ack(ack), .o_in(cin), .o_out(cout), .o_rqe(rqe));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic pulse(input int b);
        ins[b] = 1'b1;
        repeat (4) @(negedge clk);
        ins[b] = 1'b0;
        repeat (6) @(negedge clk);
    endtask : pulse
    task automatic run_op(input bit read_operation_flag, input int st, input int subs, input int words);
        logic [15:0] adr, lw, wd;
        adr = 16'($urandom);
        lw = ~{4'($urandom), 12'(subs)};
        wd = 16'($urandom);
        fmt = 16'($urandom);
        d = adr;
        pulse(1);
        `CHK(mem, ~adr)
        // Start clears the whole counter, so the length must be loaded after it.
        pulse(st);
        if (subs > 0) begin
            d = lw;
            pulse(2);
            `CHK(sub, ~lw[15:12])
            `CHK(lflag, 1'b1)
        end else begin
            `CHK(lflag, 1'b0)
        end
        d = wd;
        gates = 0;
        expq.push_back(~adr);
        repeat (read_operation_flag ? words : 0) expq.push_back(~fmt);
        wr = !read_operation_flag;
        rd = read_operation_flag;
        if (slow) begin
            for (int i = 0; i < 400 && !busy; i++) @(negedge clk);
            expq.push_back(16'h0000);
            pulse(3);
        end
        for (int i = 0; i < 80 * words + 400 && !eop; i++) @(negedge clk);
        repeat (60) @(negedge clk);
        `CHK(gates, words)
        `CHK(eop, 1'b1)
        if (!read_operation_flag) `CHK(fbus, ~wd)
        expq.push_back(~adr + 16'(words));
        pulse(3);
        wr = 1'b0;
        rd = 1'b0;
    endtask : run_op
    always @(posedge clk) begin
        oe_d <= oe;
        if (gate) gates++;
        if (utl) utl_n++;
        if (oe && !oe_d && !srs) begin
            exp_w = expq.size() ? expq.pop_front() : 16'hXXXX;
            `CHK(odat, exp_w)
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        wrap_up;
    end
    initial begin
        {rst_n, ins, d, fmt, err, int_ack, int_pnd, int_pri, prio, wr, rd, rdy, slow, oe_d} = '0;
        {bad_count, checks, gates, utl_n} = '0;
        void'($urandom(83252));
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        `CHK(pout, 1'b0)
        prio = 1'b1;
        rd = 1'b1;
        repeat (40) @(negedge clk);
        `CHK(pout, 1'b1)
        `CHK(req, 1'b0)
        rd = 1'b0;
        rdy = 1'b1;
        d = 16'($urandom);
        pulse(0);
        `CHK(fbus, ~d)
        `CHK(utl_n, 1)
        int_ack = 1'b1;
        repeat (6) @(negedge clk);
        {int_pnd, int_pri} = 2'h3;
        expq.push_back(HDCA_DEV_CODE_DEF);
        repeat (8) @(negedge clk);
        {int_ack, int_pnd, int_pri} = 3'h0;
        slow = 1'b1;
        run_op(1'b0, 4, 1, 16);
        slow = 1'b0;
        run_op(1'b1, 7, 2, 32);
        run_op(1'b0, 4, 0, 256);
        err = 6'($urandom);
        ins[6] = 1'b1;
        repeat (5) @(negedge clk);
        `CHK(srs, 1'b1)
        `CHK(oe, 1'b1)
        `CHK(odat, {10'h000, ~err})
        ins[6] = 1'b0;
        repeat (6) @(negedge clk);
        pulse(5);
        `CHK(mem, 16'h0000)
        `CHK(expq.size(), 0)
        wrap_up;
    end
endmodule : hdca_adapter_test
